// ### logic/spi_chain_pkg.sv
// Constants shared by the serial frame logic: addresses, fields and resets
package spi_chain_pkg;
  // Register addresses (6-bit command field)
  localparam logic [5:0] ADDR_DEV_ID = 6'h00;
  localparam logic [5:0] ADDR_DIGEST = 6'h01;
  localparam logic [5:0] ADDR_STATUS1 = 6'h02;
  localparam logic [5:0] ADDR_STATUS2 = 6'h03;
  localparam logic [5:0] ADDR_COMMAND = 6'h08;
  localparam logic [5:0] ADDR_OUT_CTRL = 6'h09;
  localparam logic [5:0] ADDR_LAST_CFG = 6'h0d;
  localparam int NUM_RW_REGS = 6;
  // Reset values of the writable registers, from COMMAND upward
  localparam logic [7:0] RST_COMMAND = 8'h01;
  localparam logic [7:0] RST_OUT_CTRL = 8'h0c;
  localparam logic [7:0] RST_CONFIG1 = 8'h10;
  localparam logic [7:0] RST_CONFIG2 = 8'h00;
  localparam logic [7:0] RST_CONFIG3 = 8'h40;
  localparam logic [7:0] RST_CONFIG4 = 8'h04;
  // Arbitrary identity value, not tied to any real part
  localparam logic [7:0] DEVICE_ID_DEFAULT = 8'h5a;
  // Command register fields
  localparam int CMD_CLR_BIT = 7;
  localparam int CMD_OUT_LOCK_LSB = 3;
  localparam int CMD_REG_LOCK_LSB = 0;
  localparam logic [1:0] LOCK_ON = 2'h2;
  // Frame byte layout
  localparam int FRAME_TYPE_BIT = 7;
  localparam int RW_BIT = 6;
  localparam logic [1:0] STATUS_LEAD = 2'h3;
  localparam logic [1:0] HDR_MARK = 2'h2;
  localparam logic [1:0] PASS_MARK = 2'h3;
  localparam int CHAIN_GLOBAL_HEADER_CLR_BIT = 5;
  localparam int MAX_CHAIN = 63;
  localparam logic [7:0] STD_FRAME_BYTES = 8'h02;
  localparam logic [7:0] HDR_BYTES = 8'h02;
  localparam int FIFO_DEPTH_DEFAULT = 16;
  localparam int WORD_W = 14;
endpackage

// ### logic/spi_daisy_chain_frame_logic.sv
// Serial frame decoder with chain support, write queue and register file
//
// Behaviour
// - Top command bit zero means standard frame
// - Second command bit: zero write, one read
// - Six address bits follow, MSB first
// - Second byte carries write data
// - Response status byte starts with two ones
// - Status bits: error, OV, UV, OC, OT, frame
// - Report byte returns register value before write
// - Chain holds at most sixty-three devices
// - Host gets statuses, headers, then reports
// - Header byte starts with one, zero
// - First header carries chain length
// - Zero chain length raises frame error
// - Second header clears faults at frame end
// - Five low second-header bits are ignored
// - Pass bytes are forwarded one slot later
// - Position counted from pass bytes before header
// - Capture own bytes only, forward the rest
// - Chain bytes use standard encoding
// - Writes accepted only while no earlier write waits for queue room
// - Lock fields block configuration and output writes
// - Launch on rising, sample on falling edge
// - Wrong bit count flags error, drops write
// - Idle select ignores link, floats output
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Small FIFO of flip-flops with valid/ready on both sides
module chain_word_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two, at least 2");
  end

  // Honest flags from the fill count
  assign in_ready = (count_ff != (PW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Frame logic top
module spi_daisy_chain_frame_logic #(
  parameter int FIFO_DEPTH = spi_chain_pkg::FIFO_DEPTH_DEFAULT,
  parameter logic [7:0] DEVICE_ID = spi_chain_pkg::DEVICE_ID_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic chip_select_n,
  output logic sdo,
  output logic sdo_oe_n,
  input wire logic overvoltage_event,
  input wire logic undervoltage_event,
  input wire logic overcurrent_event,
  input wire logic overtemperature_event,
  output logic [7:0] error_digest_register,
  output logic [7:0] reg_command,
  output logic [7:0] reg_out_ctrl,
  output logic [7:0] reg_config1,
  output logic [7:0] reg_config2,
  output logic [7:0] reg_config3,
  output logic [7:0] reg_config4,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [5:0] wr_addr,
  output logic [7:0] wr_data
);
  import spi_chain_pkg::*;

  localparam logic [7:0] RW_RESET [NUM_RW_REGS] = '{RST_COMMAND,
    RST_OUT_CTRL, RST_CONFIG1, RST_CONFIG2, RST_CONFIG3, RST_CONFIG4};

  // Synchronisers, edge history, link state
  logic sclk_m_ff, sclk_s_ff, sclk_d_ff;
  logic cs_m_ff, cs_s_ff, cs_d_ff;
  logic sdi_m_ff, sdi_s_ff;
  logic [6:0] rx_sh_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] byte_idx_ff;
  logic [7:0] tx_sh_ff;
  logic sdo_ff, sdo_oe_n_ff;
  // Frame decode state
  logic chain_ff, hdr_seen_ff, hdr_err_ff, clr_req_ff;
  logic [7:0] hdr_idx_ff;
  logic [5:0] pos_ff, n_ff, addr_ff;
  logic rw_ff, cmd_seen_ff;
  logic [7:0] data_ff;
  // Fault flags
  logic supply_overvoltage_flag_ff, supply_undervoltage_flag_ff;
  logic overcurrent_flag_ff, overtemperature_flag_ff, frame_err_ff;
  // Register file and write queue
  logic [7:0] rw_regs_ff [NUM_RW_REGS];
  logic pend_ff;
  logic [WORD_W-1:0] pend_word_ff;
  logic wr_valid_ff;
  logic [5:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [WORD_W-1:0] fifo_out_data;

  // Combinational terms
  logic sclk_rise, sclk_fall, cs_fall, frame_end, byte_done;
  logic [7:0] rx_byte, n_plus1, n_data, exp_bytes, rd_val;
  logic is_cmd, is_data, cnt_ok, frame_ok, addr_ok, writable, clr_evt;
  logic cfg_locked, out_locked, cmd_clr;
  logic [7:0] status_byte;
  logic [7:0] digest_ff;

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("FIFO_DEPTH must be at least 2");
  end

  //////////////////////////////////////////////////////////////////////////
  // Link sampling: two flip-flops on every pin before use
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclk_m_ff <= 1'b0;
      sclk_s_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      cs_m_ff <= 1'b1;
      cs_s_ff <= 1'b1;
      cs_d_ff <= 1'b1;
      sdi_m_ff <= 1'b0;
      sdi_s_ff <= 1'b0;
    end else begin
      sclk_m_ff <= sclk;
      sclk_s_ff <= sclk_m_ff;
      sclk_d_ff <= sclk_s_ff;
      cs_m_ff <= chip_select_n;
      cs_s_ff <= cs_m_ff;
      cs_d_ff <= cs_s_ff;
      sdi_m_ff <= sdi;
      sdi_s_ff <= sdi_m_ff;
    end
  end

  // Edges count only while selected
  assign sclk_rise = sclk_s_ff && !sclk_d_ff && !cs_s_ff;
  assign sclk_fall = !sclk_s_ff && sclk_d_ff && !cs_s_ff;
  assign cs_fall = !cs_s_ff && cs_d_ff;
  assign frame_end = cs_s_ff && !cs_d_ff;
  assign byte_done = sclk_fall && (bit_cnt_ff == 3'h7);
  assign rx_byte = {rx_sh_ff, sdi_s_ff};

  // Chain slot positions, independent of own position
  assign n_plus1 = {2'h0, n_ff} + 8'h01;
  assign n_data = {1'b0, n_ff, 1'b1};
  assign exp_bytes = chain_ff ? ({1'b0, n_ff, 1'b0} + HDR_BYTES)
                              : STD_FRAME_BYTES;
  assign is_cmd = (byte_idx_ff == 8'h00 && !rx_byte[FRAME_TYPE_BIT])
    || (chain_ff && hdr_seen_ff && byte_idx_ff == n_plus1);
  assign is_data = (!chain_ff && cmd_seen_ff && byte_idx_ff == 8'h01)
    || (chain_ff && hdr_seen_ff && byte_idx_ff == n_data);

  //////////////////////////////////////////////////////////////////////////
  // Status byte and register read mux
  // Digest register mirrors the flags one clock later
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      digest_ff <= 8'h00;
    end else begin
      digest_ff <= {frame_err_ff, 1'b0, |status_byte[5:1],
        supply_overvoltage_flag_ff, supply_undervoltage_flag_ff,
        overcurrent_flag_ff, overtemperature_flag_ff, 1'b0};
    end
  end
  assign error_digest_register = digest_ff;
  assign status_byte = {STATUS_LEAD,
    supply_overvoltage_flag_ff | supply_undervoltage_flag_ff |
    overcurrent_flag_ff | overtemperature_flag_ff | frame_err_ff,
    supply_overvoltage_flag_ff, supply_undervoltage_flag_ff,
    overcurrent_flag_ff, overtemperature_flag_ff, frame_err_ff};

  // Read value of the address in the byte just received
  always_comb begin
    rd_val = 8'h00;
    if (rx_byte[5:0] == ADDR_DEV_ID) begin
      rd_val = DEVICE_ID;
    end else if (rx_byte[5:0] == ADDR_DIGEST) begin
      rd_val = error_digest_register;
    end else if (rx_byte[5:0] >= ADDR_COMMAND &&
                 rx_byte[5:0] <= ADDR_LAST_CFG) begin
      rd_val = rw_regs_ff[3'(rx_byte[5:0] - ADDR_COMMAND)];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bit shifting: sample on falling edge, launch on rising edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_sh_ff <= 7'h00;
      bit_cnt_ff <= 3'h0;
      byte_idx_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      sdo_ff <= 1'b0;
      sdo_oe_n_ff <= 1'b1;
    end else begin
      sdo_oe_n_ff <= cs_s_ff;
      if (cs_fall) begin
        bit_cnt_ff <= 3'h0;
        byte_idx_ff <= 8'h00;
        tx_sh_ff <= status_byte;
      end else if (sclk_fall) begin
        rx_sh_ff <= rx_byte[6:0];
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (byte_done) begin
          if (byte_idx_ff != 8'hff) begin
            byte_idx_ff <= byte_idx_ff + 8'h01;
          end
          // Own command slot answers with report, else forward
          tx_sh_ff <= is_cmd ? rd_val : rx_byte;
        end
      end else if (sclk_rise) begin
        sdo_ff <= tx_sh_ff[7];
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame decode: type, headers, position, own bytes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chain_ff <= 1'b0;
      hdr_seen_ff <= 1'b0;
      hdr_err_ff <= 1'b0;
      clr_req_ff <= 1'b0;
      hdr_idx_ff <= 8'h00;
      pos_ff <= 6'h00;
      n_ff <= 6'h00;
      addr_ff <= 6'h00;
      rw_ff <= 1'b0;
      cmd_seen_ff <= 1'b0;
      data_ff <= 8'h00;
    end else if (cs_fall) begin
      chain_ff <= 1'b0;
      hdr_seen_ff <= 1'b0;
      hdr_err_ff <= 1'b0;
      clr_req_ff <= 1'b0;
      pos_ff <= 6'h00;
      n_ff <= 6'h00;
      cmd_seen_ff <= 1'b0;
    end else if (byte_done) begin
      if (byte_idx_ff == 8'h00) begin
        chain_ff <= rx_byte[FRAME_TYPE_BIT];
      end
      if ((byte_idx_ff == 8'h00 && rx_byte[FRAME_TYPE_BIT]) ||
          (chain_ff && !hdr_seen_ff)) begin
        if (rx_byte[7:6] == PASS_MARK) begin
          if (pos_ff != 6'(MAX_CHAIN)) begin
            pos_ff <= pos_ff + 6'h01;
          end
        end else if (rx_byte[7:6] == HDR_MARK) begin
          hdr_seen_ff <= 1'b1;
          hdr_idx_ff <= byte_idx_ff;
          n_ff <= rx_byte[5:0];
        end else begin
          hdr_err_ff <= 1'b1;
        end
      end
      // Second header: mark bits are checked, otherwise only the clear bit counts
      if (chain_ff && hdr_seen_ff &&
          byte_idx_ff == hdr_idx_ff + 8'h01) begin
        if (rx_byte[7:6] != HDR_MARK) begin
          hdr_err_ff <= 1'b1;
        end
        clr_req_ff <= rx_byte[CHAIN_GLOBAL_HEADER_CLR_BIT];
      end
      if (is_cmd) begin
        cmd_seen_ff <= 1'b1;
        rw_ff <= rx_byte[RW_BIT];
        addr_ff <= rx_byte[5:0];
        if (chain_ff && rx_byte[FRAME_TYPE_BIT]) begin
          hdr_err_ff <= 1'b1;
        end
      end
      if (is_data) begin
        data_ff <= rx_byte;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame end checks and write commit
  assign cnt_ok = (bit_cnt_ff == 3'h0) && (byte_idx_ff == exp_bytes);
  assign addr_ok = (addr_ff <= ADDR_STATUS2) ||
    (addr_ff >= ADDR_COMMAND && addr_ff <= ADDR_LAST_CFG);
  assign frame_ok = cnt_ok && cmd_seen_ff && addr_ok && !hdr_err_ff &&
    (!chain_ff || (hdr_seen_ff && n_ff != 6'h00));
  assign cfg_locked =
    rw_regs_ff[0][CMD_REG_LOCK_LSB +: 2] == LOCK_ON;
  assign out_locked =
    rw_regs_ff[0][CMD_OUT_LOCK_LSB +: 2] == LOCK_ON;
  always_comb begin
    writable = 1'b0;
    if (addr_ff == ADDR_COMMAND) begin
      writable = 1'b1;
    end else if (addr_ff == ADDR_OUT_CTRL) begin
      writable = !out_locked;
    end else if (addr_ff > ADDR_OUT_CTRL && addr_ff <= ADDR_LAST_CFG) begin
      writable = !cfg_locked;
    end
  end

  // Commit waits for room in the queue
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend_ff <= 1'b0;
      pend_word_ff <= '0;
    end else if (frame_end && frame_ok && !rw_ff && writable &&
                 !pend_ff) begin
      pend_ff <= 1'b1;
      pend_word_ff <= {addr_ff, data_ff};
    end else if (pend_ff && fifo_in_ready) begin
      pend_ff <= 1'b0;
    end
  end

  chain_word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(pend_ff),
    .in_ready(fifo_in_ready),
    .in_data(pend_word_ff),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Output stage refills when empty or taken
  assign fifo_pop = fifo_out_valid && (!wr_valid_ff || wr_ready);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_valid_ff <= 1'b0;
      wr_addr_ff <= 6'h00;
      wr_data_ff <= 8'h00;
    end else if (!wr_valid_ff || wr_ready) begin
      wr_valid_ff <= fifo_out_valid;
      wr_addr_ff <= fifo_out_data[WORD_W-1:8];
      wr_data_ff <= fifo_out_data[7:0];
    end
  end

  // Register file takes the write when the consumer accepts it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < NUM_RW_REGS; i++) begin
        rw_regs_ff[i] <= RW_RESET[i];
      end
    end else if (wr_valid_ff && wr_ready) begin
      rw_regs_ff[3'(wr_addr_ff - ADDR_COMMAND)] <= wr_data_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky fault flags: a new event wins over a clear
  assign cmd_clr = wr_valid_ff && wr_ready && wr_addr_ff == ADDR_COMMAND
    && wr_data_ff[CMD_CLR_BIT];
  assign clr_evt = (frame_end && frame_ok && chain_ff && clr_req_ff)
    || cmd_clr;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      supply_overvoltage_flag_ff <= 1'b0;
      supply_undervoltage_flag_ff <= 1'b0;
      overcurrent_flag_ff <= 1'b0;
      overtemperature_flag_ff <= 1'b0;
      frame_err_ff <= 1'b0;
    end else begin
      supply_overvoltage_flag_ff <= overvoltage_event ||
        (supply_overvoltage_flag_ff && !clr_evt);
      supply_undervoltage_flag_ff <= undervoltage_event ||
        (supply_undervoltage_flag_ff && !clr_evt);
      overcurrent_flag_ff <= overcurrent_event ||
        (overcurrent_flag_ff && !clr_evt);
      overtemperature_flag_ff <= overtemperature_event ||
        (overtemperature_flag_ff && !clr_evt);
      frame_err_ff <= (frame_end && (!frame_ok ||
        (!rw_ff && writable && pend_ff))) ||
        (frame_err_ff && !clr_evt);
    end
  end

  // Outputs
  assign sdo = sdo_ff;
  assign sdo_oe_n = sdo_oe_n_ff;
  assign reg_command = rw_regs_ff[0];
  assign reg_out_ctrl = rw_regs_ff[1];
  assign reg_config1 = rw_regs_ff[2];
  assign reg_config2 = rw_regs_ff[3];
  assign reg_config3 = rw_regs_ff[4];
  assign reg_config4 = rw_regs_ff[5];
  assign wr_valid = wr_valid_ff;
  assign wr_addr = wr_addr_ff;
  assign wr_data = wr_data_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_status_lead: assert property (@(posedge clk_sys) disable iff (reset)
    cs_fall |=> tx_sh_ff[7:6] == STATUS_LEAD && !sdo_oe_n_ff)
    else $error("status byte lead bits wrong");

  a_output_float: assert property (@(posedge clk_sys) disable iff (reset)
    cs_s_ff [*2] |-> sdo_oe_n_ff && $stable(tx_sh_ff))
    else $error("output driven while deselected");

  a_zero_length: assert property (@(posedge clk_sys) disable iff (reset)
    (frame_end && chain_ff && hdr_seen_ff && n_ff == 6'h00)
    |=> frame_err_ff && !$rose(pend_ff))
    else $error("zero chain length not flagged");

  a_bad_count: assert property (@(posedge clk_sys) disable iff (reset)
    (frame_end && !cnt_ok) |=> frame_err_ff && !$rose(pend_ff))
    else $error("bad bit count not flagged");

  a_commit_late: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(pend_ff) |-> $past(frame_end) && $past(cnt_ok))
    else $error("write committed outside frame end");

  a_cfg_lock: assert property (@(posedge clk_sys) disable iff (reset)
    ($rose(pend_ff) && pend_word_ff[13:8] > ADDR_OUT_CTRL)
    |-> !$past(cfg_locked))
    else $error("locked configuration written");

  a_report_slot: assert property (@(posedge clk_sys) disable iff (reset)
    (byte_done && is_cmd) |=> tx_sh_ff == $past(rd_val))
    else $error("report byte not loaded");

  a_pass_forward: assert property (@(posedge clk_sys) disable iff (reset)
    (byte_done && !is_cmd && rx_byte[7:6] == PASS_MARK)
    |=> tx_sh_ff == $past(rx_byte) ##1 tx_sh_ff[7] == $past(rx_byte[7], 2))
    else $error("pass byte not forwarded");

  a_global_clear: assert property (@(posedge clk_sys) disable iff (reset)
    (frame_end && frame_ok && chain_ff && clr_req_ff && !overvoltage_event
     && !overcurrent_event) |=> !supply_overvoltage_flag_ff
     && !overcurrent_flag_ff && !frame_err_ff)
    else $error("global clear not applied");

  a_position_count: assert property (@(posedge clk_sys) disable iff (reset)
    (byte_done && (chain_ff || byte_idx_ff == 8'h00) && !hdr_seen_ff
     && rx_byte[7:6] == PASS_MARK && pos_ff != 6'h3f)
    |=> pos_ff == $past(pos_ff) + 6'h01)
    else $error("chain position not counted");
endmodule

// ### verif/spi_host_model.sv
// Host-side serial controller model driving frames into the frame logic
`timescale 1ns/10ps
module spi_host_model (
  input wire logic clk_sys,
  output logic sclk,
  output logic sdi,
  output logic chip_select_n,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  logic oe_bad;
  logic sdo_line;
  // A released output line reads as the inverse of the last driven bit
  assign sdo_line = sdo_oe_n ? ~sdo : sdo;
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    chip_select_n = 1'b1;
    oe_bad = 1'b0;
  end
  // Idle data line toggles so a stale level never looks like a bit
  always @(posedge clk_sys) begin
    if (chip_select_n) begin
      sdi <= ~sdi;
    end
  end
  // One frame of nbits, MSB first; data set with the rise, read late
  task automatic frame(input int nbits, input logic [63:0] tx,
                       output logic [63:0] rx);
    rx = '0;
    @(posedge clk_sys);
    chip_select_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi <= tx[i];
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rx[i] = sdo_line;
      if (sdo_oe_n !== 1'b0) begin
        oe_bad = 1'b1;
      end
    end
    chip_select_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// ### verif/tb_spi_daisy_chain_frame_logic.sv
// Self-checking bench for the serial frame logic
`timescale 1ns/10ps
module tb_spi_daisy_chain_frame_logic;
  import spi_chain_pkg::*;
  logic clk_sys, reset, sclk, sdi, chip_select_n, sdo, sdo_oe_n;
  logic wr_valid, wr_ready;
  logic [3:0] ev;
  logic [7:0] digest, r_cmd, r_out, r_c1, r_c2, r_c3, r_c4, wr_data;
  logic [5:0] wr_addr;
  logic [63:0] rx;
  logic [3:0] acc;
  int n_errors = 0;
  int samples_checked = 0;
  int n_wr = 0;
  int n_wr_seen = 0;

  // Count writes taken by the consumer side
  always @(posedge clk_sys) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      n_wr <= n_wr + 1;
    end
  end

  spi_daisy_chain_frame_logic uut (.clk_sys(clk_sys), .reset(reset),
    .sclk(sclk), .sdi(sdi), .chip_select_n(chip_select_n), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .overvoltage_event(ev[3]),
    .undervoltage_event(ev[2]), .overcurrent_event(ev[1]),
    .overtemperature_event(ev[0]), .error_digest_register(digest),
    .reg_command(r_cmd), .reg_out_ctrl(r_out), .reg_config1(r_c1),
    .reg_config2(r_c2), .reg_config3(r_c3), .reg_config4(r_c4),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data));
  spi_host_model host (.clk_sys(clk_sys), .sclk(sclk), .sdi(sdi),
    .chip_select_n(chip_select_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic test_done();
    $display("checked %0d values, %0d wrong", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0h", $time, what, got);
    end
  endtask
  // Bounded wait for a committed write, then let the handshake land
  task automatic wait_commit(input bit must);
    int k;
    k = 0;
    while (wr_valid !== 1'b1 && n_wr == n_wr_seen && k < 40) begin
      @(posedge clk_sys);
      k++;
    end
    n_wr_seen = n_wr;
    if (must && k == 40) begin
      n_errors++;
      $display("wrong value at %0t: no write offered", $time);
      test_done();
    end
    repeat (2) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk({r_cmd, r_out, r_c1, r_c2, r_c3, r_c4}, {RST_COMMAND,
      RST_OUT_CTRL, RST_CONFIG1, RST_CONFIG2, RST_CONFIG3, RST_CONFIG4},
      "reset regs");
    chk({digest, wr_valid, sdo_oe_n}, {8'h00, 2'b01}, "reset out");
    $display("test reset done");
  endtask
  task automatic t_std();
    host.frame(16, {2'b01, ADDR_DEV_ID, 8'h00}, rx);
    chk(rx[15:0], {STATUS_LEAD, 6'h00, DEVICE_ID_DEFAULT}, "id");
    @(posedge clk_sys);
    wr_ready <= 1'b0;
    host.frame(16, {2'b00, 6'h0a, 8'h5c}, rx);
    chk(rx[15:0], {8'hc0, RST_CONFIG1}, "wr report");
    wait_commit(1'b1);
    chk({wr_addr, wr_data, r_c1}, {6'h0a, 8'h5c, RST_CONFIG1}, "wr");
    wr_ready <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(r_c1, 8'h5c, "cfg1");
    host.frame(16, {2'b01, 6'h0a, 8'h00}, rx);
    chk(rx[15:0], {8'hc0, 8'h5c}, "readback");
    $display("test standard done");
  endtask
  task automatic t_badcount();
    host.frame(15, {2'b00, 6'h0b, 7'h3b}, rx);
    wait_commit(1'b0);
    chk({digest, r_c2}, {8'ha0, RST_CONFIG2}, "short frame");
    $display("test bit count done");
  endtask
  // Single-device chain frame with the global clear bit and spare bits
  task automatic t_chain_clr(input logic [7:0] st);
    host.frame(32, {8'h81, 8'hb5, 8'h48, 8'h00}, rx);
    chk(rx[31:0], {st, 8'h81, 8'hb5, RST_COMMAND}, "chain");
    chk(digest, 8'h00, "cleared");
    $display("test chain clear done");
  endtask
  task automatic t_zero_chain();
    host.frame(16, {8'h80, 8'h80}, rx);
    chk(digest, 8'ha0, "zero chain");
    $display("test zero chain done");
  endtask
  task automatic t_faults();
    acc = 4'h0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      ev <= 4'h8 >> i;
      @(posedge clk_sys);
      ev <= 4'h0;
      acc = acc | (4'h8 >> i);
      host.frame(16, {2'b01, ADDR_DIGEST, 8'h00}, rx);
      chk(rx[15:8], {3'b111, acc, 1'b1}, "status");
      chk(digest, {3'b101, acc, 1'b0}, "digest");
      chk(rx[7:0], {3'b101, acc, 1'b0}, "digest read");
    end
    $display("test faults done");
  endtask
  // Second device of two: one pass byte ahead of the headers
  task automatic t_pass();
    host.frame(48, {8'hc5, 8'h82, 8'h80, 8'h0b, 8'hd2, 8'h33}, rx);
    chk(rx[47:0], {8'hc0, 8'hc5, 8'h82, 8'h80, RST_CONFIG2, 8'hd2},
      "pass");
    wait_commit(1'b1);
    chk(r_c2, 8'h33, "own write");
    $display("test pass done");
  endtask
  task automatic t_lock();
    host.frame(16, {2'b00, ADDR_COMMAND, 8'h02}, rx);
    wait_commit(1'b1);
    chk(r_cmd, 8'h02, "lock on");
    host.frame(16, {2'b00, 6'h0c, 8'h55}, rx);
    wait_commit(1'b0);
    chk(r_c3, RST_CONFIG3, "locked cfg3");
    host.frame(16, {2'b00, ADDR_OUT_CTRL, 8'h03}, rx);
    wait_commit(1'b1);
    chk(r_out, 8'h03, "out ctrl");
    host.frame(16, {2'b01, 6'h3f, 8'h00}, rx);
    chk(digest, 8'ha0, "unmapped");
    host.frame(16, {2'b00, ADDR_COMMAND, 8'h90}, rx);
    wait_commit(1'b1);
    chk({r_cmd, digest}, {8'h90, 8'h00}, "clear cmd");
    host.frame(16, {2'b00, ADDR_OUT_CTRL, 8'h05}, rx);
    wait_commit(1'b0);
    chk(r_out, 8'h03, "locked out");
    chk(host.oe_bad, 1'b0, "drive");
    $display("test lock done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    ev = 4'h0;
    wr_ready = 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (6) @(posedge clk_sys);
    t_reset();
    t_std();
    t_badcount();
    t_chain_clr(8'he1);
    t_zero_chain();
    t_faults();
    t_chain_clr(8'hff);
    t_pass();
    t_lock();
    test_done();
  end
endmodule
